// ==== logic/rdac_pkg.sv ====
package rdac_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL0 = 12'h000;
   localparam logic [11:0] ADDR_LEVEL = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_ENABLE = 7;
   localparam int BIT_LPS = 6;
   localparam int BIT_OE = 5;
   localparam int BIT_PSS_HI = 3;
   localparam int BIT_PSS_LO = 2;
   localparam int LEVEL_W = 5;
   localparam int TAPS = 32;

   localparam logic [7:0] CTRL0_WMASK = 8'hec;
   localparam logic [7:0] LEVEL_WMASK = 8'h1f;
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [4:0] LEVEL_RST = 5'h00;
   localparam logic [4:0] LEVEL_ALL_ONES = 5'h1f;
   localparam logic [4:0] LEVEL_ALL_ZERO = 5'h00;

   typedef enum logic [1:0] {
      RDAC_SRC_SUPPLY = 2'b00,
      RDAC_SRC_EXTPIN = 2'b01,
      RDAC_SRC_FIXED = 2'b10,
      RDAC_SRC_RSVD = 2'b11
   } rdac_src_t;

   // Analog network controls, one bundle
   typedef struct packed {
      logic [31:0] tap_sel;
      logic upper_conn;
      logic lower_conn;
      logic src_supply;
      logic src_extpin;
      logic src_fixed;
      logic route_cmp;
      logic route_adc;
      logic route_pin;
      logic route_cps;
   } rdac_analog_t;

   // Reset image equals the decode of all-zero registers, so no false step at release
   localparam rdac_analog_t ANALOG_RST = '{
      tap_sel: 32'h0000_0001,
      upper_conn: 1'b0,
      lower_conn: 1'b1,
      src_supply: 1'b1,
      src_extpin: 1'b0,
      src_fixed: 1'b0,
      route_cmp: 1'b1,
      route_adc: 1'b1,
      route_pin: 1'b0,
      route_cps: 1'b1
   };

endpackage

// ==== logic/rdac_top.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Enable bit 7 of control zero turns the converter on or off.
// - Exactly 32 output levels chosen by a 5-bit level code.
// - When enabled, tap equals level code over 32 of the span.
// - Source field 00 supply, 01 external pin, 10 fixed reference; 11 reserved.
// - Output can be routed to comparator, converter, pin and sensing.
// - Pin enable places level on pin, overriding digital driver and detector.
// - Digital reads of the pin return zero while it carries the level.
// - When disabled, low-power side one drops lower reference, zero drops upper reference.
// - Disabled, side one, code all ones clamps output to upper reference.
// - Disabled, side zero, code all zeros clamps output to lower reference.
// - Control zero is unchanged across wake from sleep.
// - Reset disables converter, frees pin and clears level code.
// - Level code in bits 4-0 of level register, upper bits read zero.
module rdac_top #(
   parameter int LEVELS = 32
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pin_digital_in,
   input wire logic pin_digital_out,
   input wire logic pin_digital_oe,
   output logic pin_read_value,
   output logic pin_drive_out,
   output logic pin_drive_oe,
   output logic pin_input_det_en,
   output rdac_pkg::rdac_analog_t analog_ctl
);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [7:0] ctrl0_reg;
   logic [7:0] ctrl0_next;
   logic [4:0] level_reg;
   logic [4:0] level_next;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pslverr_next;

   wire setup_phase = psel && !penable;
   wire access_now = psel && penable && pready_reg;
   wire wr_now = access_now && pwrite && pstrb[0];
   wire hit_ctrl0 = paddr == rdac_pkg::ADDR_CTRL0;
   wire hit_level = paddr == rdac_pkg::ADDR_LEVEL;
   wire hit_status = paddr == rdac_pkg::ADDR_STATUS;
   wire hit_any = hit_ctrl0 || hit_level || hit_status;

   wire en = ctrl0_reg[rdac_pkg::BIT_ENABLE];
   wire lps = ctrl0_reg[rdac_pkg::BIT_LPS];
   wire oe = ctrl0_reg[rdac_pkg::BIT_OE];
   wire [1:0] pss = ctrl0_reg[rdac_pkg::BIT_PSS_HI:rdac_pkg::BIT_PSS_LO];

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   // masked bits
   assign ctrl0_next = (wr_now && hit_ctrl0) ?
      (pwdata[7:0] & rdac_pkg::CTRL0_WMASK) : ctrl0_reg;
   assign level_next = (wr_now && hit_level) ?
      pwdata[rdac_pkg::LEVEL_W-1:0] : level_reg;

   // Status word mirrors live analog state for software
   wire [31:0] status_word = {21'h0, analog_ctl.route_pin, analog_ctl.upper_conn,
      analog_ctl.lower_conn, en, level_reg, pss};

   assign prdata_next = !hit_ctrl0 ? (hit_level ? {27'h0, level_reg} :
      (hit_status ? status_word : 32'h0)) : {24'h0, ctrl0_reg};
   assign pslverr_next = psel && penable && !hit_any;

   // no sleep input: contents only change on write or reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl0_reg <= rdac_pkg::CTRL0_RST;
         level_reg <= rdac_pkg::LEVEL_RST;
      end else begin
         ctrl0_reg <= ctrl0_next;
         level_reg <= level_next;
      end
   end

   // One wait state: ready rises in the first access cycle's following edge
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pready_reg <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready_reg <= psel && penable && !pready_reg;
         prdata <= (psel && penable && !pready_reg) ? prdata_next : prdata;
         pslverr <= (psel && penable && !pready_reg) ? pslverr_next : 1'b0;
      end
   end
   assign pready = pready_reg;

   // ---------------------------------------------------------------
   // Analog control decode
   // ---------------------------------------------------------------
   function automatic logic [31:0] tap_decode(input logic [4:0] code);
      tap_decode = 32'h1 << code;
   endfunction

   rdac_pkg::rdac_analog_t ana_next;
   wire [4:0] code_n = level_next;
   wire [7:0] c0n = ctrl0_next;
   wire en_n = c0n[rdac_pkg::BIT_ENABLE];
   wire lps_n = c0n[rdac_pkg::BIT_LPS];
   wire oe_n = c0n[rdac_pkg::BIT_OE];
   wire [1:0] pss_n = c0n[rdac_pkg::BIT_PSS_HI:rdac_pkg::BIT_PSS_LO];

   // low-power side disconnects one end when off
   assign ana_next.tap_sel = tap_decode(code_n);
   assign ana_next.upper_conn = en_n || lps_n;
   assign ana_next.lower_conn = en_n || !lps_n;
   // source decode, reserved code selects nothing
   assign ana_next.src_supply = pss_n == rdac_pkg::RDAC_SRC_SUPPLY;
   assign ana_next.src_extpin = pss_n == rdac_pkg::RDAC_SRC_EXTPIN;
   assign ana_next.src_fixed = pss_n == rdac_pkg::RDAC_SRC_FIXED;
   assign ana_next.route_cmp = 1'b1;
   assign ana_next.route_adc = 1'b1;
   assign ana_next.route_cps = 1'b1;
   assign ana_next.route_pin = oe_n;

   // registered controls change once, one edge after the write
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         analog_ctl <= rdac_pkg::ANALOG_RST;
      end else begin
         analog_ctl <= ana_next;
      end
   end

   // ---------------------------------------------------------------
   // Pin override
   // ---------------------------------------------------------------
   // digital driver and detector overridden
   // reads return zero while pin is analog
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pin_drive_out <= 1'b0;
         pin_drive_oe <= 1'b0;
         pin_input_det_en <= 1'b1;
         pin_read_value <= 1'b0;
      end else begin
         pin_drive_out <= oe_n ? 1'b0 : pin_digital_out;
         pin_drive_oe <= oe_n ? 1'b0 : pin_digital_oe;
         pin_input_det_en <= !oe_n;
         pin_read_value <= oe_n ? 1'b0 : pin_digital_in;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_enable_tap: assert property (@(posedge sys_clk) disable iff (!rst_n)
      en |-> analog_ctl.tap_sel == (32'h1 << level_reg))
      else $error("tap does not match level code");
   chk_tap_onehot: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $onehot(analog_ctl.tap_sel))
      else $error("tap select not one-hot");
   chk_lps_side: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !en |-> (analog_ctl.upper_conn == lps && analog_ctl.lower_conn == !lps))
      else $error("low-power side wrong");
   chk_enable_both: assert property (@(posedge sys_clk) disable iff (!rst_n)
      en |-> (analog_ctl.upper_conn && analog_ctl.lower_conn))
      else $error("enabled ladder not fully connected");
   chk_clamp_upper: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!en && lps && level_reg == rdac_pkg::LEVEL_ALL_ONES) |->
      (analog_ctl.tap_sel[31] && !analog_ctl.lower_conn))
      else $error("upper clamp wrong");
   chk_clamp_lower: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!en && !lps && level_reg == rdac_pkg::LEVEL_ALL_ZERO) |->
      (analog_ctl.tap_sel[0] && !analog_ctl.upper_conn))
      else $error("lower clamp wrong");
   chk_src_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pss == rdac_pkg::RDAC_SRC_FIXED) |-> (analog_ctl.src_fixed && !analog_ctl.src_supply))
      else $error("source decode wrong");
   chk_pin_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      oe |-> (!pin_read_value && !pin_drive_oe && !pin_input_det_en && analog_ctl.route_pin))
      else $error("pin not overridden");
   chk_unimpl_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ctrl0_reg & ~rdac_pkg::CTRL0_WMASK) == 8'h00)
      else $error("unimplemented bits set");
   chk_write_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_now && hit_level) |=> analog_ctl.tap_sel == (32'h1 << $past(pwdata[4:0])))
      else $error("write not applied next edge");
   chk_reset_state: assert property (@(posedge sys_clk)
      $past(!rst_n) |-> (level_reg == 5'h00 && !en && !analog_ctl.route_pin))
      else $error("reset state wrong");
   // pin left digital when not enabled
   chk_pin_free: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !oe |-> (pin_input_det_en && !analog_ctl.route_pin))
      else $error("pin held analog while disabled");
   chk_src_supply: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pss == rdac_pkg::RDAC_SRC_SUPPLY) |->
      (analog_ctl.src_supply && !analog_ctl.src_extpin && !analog_ctl.src_fixed))
      else $error("supply source decode wrong");
   chk_src_extpin: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pss == rdac_pkg::RDAC_SRC_EXTPIN) |->
      (analog_ctl.src_extpin && !analog_ctl.src_supply && !analog_ctl.src_fixed))
      else $error("external source decode wrong");
   // Reserved code must never close any source switch
   chk_src_rsvd: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pss == rdac_pkg::RDAC_SRC_RSVD) |->
      !(analog_ctl.src_extpin || analog_ctl.src_supply || analog_ctl.src_fixed))
      else $error("reserved source closed a switch");
   chk_routes_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
      analog_ctl.route_cmp && analog_ctl.route_adc && analog_ctl.route_cps)
      else $error("internal route dropped");
   // Error flag only travels with ready
   chk_err_ready: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pslverr |-> pready)
      else $error("error without ready");
   chk_pin_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
      oe |-> !pin_drive_out)
      else $error("pin driven while analog");

   cov_enable: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(en));
   cov_clamp_hi: cover property (@(posedge sys_clk) disable iff (!rst_n)
      !en && lps && level_reg == rdac_pkg::LEVEL_ALL_ONES);
   cov_pin_out: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(oe));
   cov_bad_addr: cover property (@(posedge sys_clk) disable iff (!rst_n) pslverr);

endmodule

// ==== tb/rdac_ladder_model.sv ====
`timescale 1ns/10ps
// ------------------------------
// Ladder level in 32nds of span
// ------------------------------
module rdac_ladder_model (
   input wire rdac_pkg::rdac_analog_t analog_ctl,
   output logic [5:0] vout,
   output logic [1:0] src
);
   always_comb begin
      vout = 6'h00;
      for (int i = 0; i < 32; i++) begin
         if (analog_ctl.tap_sel[i]) begin
            vout = 6'(i);
         end
      end
      if (!analog_ctl.lower_conn) begin
         vout = analog_ctl.upper_conn ? 6'h20 : 6'h00;
      end else if (!analog_ctl.upper_conn) begin
         vout = 6'h00;
      end
      src = analog_ctl.src_supply ? 2'h0 : analog_ctl.src_extpin ? 2'h1 :
            analog_ctl.src_fixed ? 2'h2 : 2'h3;
   end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic pin_read_value, pin_drive_out, pin_drive_oe, pin_input_det_en;
   rdac_pkg::rdac_analog_t analog_ctl;
   logic [5:0] vout;
   logic [1:0] src;
   int mismatches, comparisons;
   typedef struct packed {logic [7:0] c; logic [7:0] l; logic [5:0] v; logic [1:0] s;} rdac_row_t;
   rdac_row_t rows [6];
   rdac_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_digital_in(1'b1), .pin_digital_out(1'b1),
      .pin_digital_oe(1'b1), .pin_read_value(pin_read_value), .pin_drive_out(pin_drive_out),
      .pin_drive_oe(pin_drive_oe), .pin_input_det_en(pin_input_det_en),
      .analog_ctl(analog_ctl));
   rdac_ladder_model ladder (.analog_ctl(analog_ctl), .vout(vout), .src(src));
   // --------------
   // Bus and checks
   // --------------
   task automatic give_verdict();
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // Wait state count is the slave's business, so poll with a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      mismatches = 0;
      comparisons = 0;
      rows = '{{8'h80, 8'he5, 6'h05, 2'h0}, {8'h84, 8'hff, 6'h1f, 2'h1},
               {8'h88, 8'he0, 6'h00, 2'h2}, {8'h44, 8'h1f, 6'h20, 2'h1},
               {8'h00, 8'h00, 6'h00, 2'h0}, {8'hbf, 8'h10, 6'h10, 2'h3}};
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b1, 12'h000, rows[i].c, 4'hf);
         apb(1'b1, 12'h004, rows[i].l, 4'hf);
         repeat (2) @(negedge sys_clk);
         ck("vout", 32'(rows[i].v), 32'(vout));
         ck("src", 32'(rows[i].s), 32'(src));
         ck("ends", rows[i].c[7] ? 32'h3 : rows[i].c[6] ? 32'h2 : 32'h1,
            32'({analog_ctl.upper_conn, analog_ctl.lower_conn}));
         ck("routes", 32'h7, 32'({analog_ctl.route_cmp, analog_ctl.route_adc,
            analog_ctl.route_cps}));
         ck("pin", rows[i].c[5] ? 32'h8 : 32'h7, 32'({analog_ctl.route_pin,
            pin_drive_out, pin_drive_oe, pin_input_det_en}));
         ck("pin_rd", 32'(!rows[i].c[5]), 32'(pin_read_value));
         apb(1'b0, 12'h000, 8'h00, 4'h0);
         ck("ctrl0", 32'(rows[i].c & 8'hec), rd);
         apb(1'b0, 12'h004, 8'h00, 4'h0);
         ck("level", 32'(rows[i].l & 8'h1f), rd);
      end
      apb(1'b1, 12'h000, 8'h80, 4'hf);
      for (int i = 0; i < 32; i++) begin
         apb(1'b1, 12'h004, 8'(i), 4'hf);
         @(negedge sys_clk);
         ck("tap", 32'h1 << i, analog_ctl.tap_sel);
      end
      apb(1'b1, 12'h000, 8'ha0, 4'hf);
      @(negedge sys_clk);
      ck("next_edge", 32'h1, 32'(analog_ctl.route_pin));
      apb(1'b1, 12'h000, 8'h00, 4'he);
      apb(1'b1, 12'h00c, 8'hff, 4'hf);
      apb(1'b0, 12'h00c, 8'h00, 4'h0);
      ck("unmapped", 32'h1, {rd[30:0], err});
      apb(1'b0, 12'h000, 8'h00, 4'h0);
      ck("strb_off", 32'ha0, rd);
      apb(1'b0, 12'h008, 8'h00, 4'h0);
      ck("status", 32'h7fc, rd);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(1'b0, 12'h000, 8'h00, 4'h0);
      ck("rst_ctrl0", 32'h0, rd);
      apb(1'b0, 12'h004, 8'h00, 4'h0);
      ck("rst_level", 32'h0, rd);
      ck("rst_pin", 32'h1, 32'({analog_ctl.route_pin, pin_input_det_en}));
      give_verdict();
   end
endmodule
